// ==== hw/dac_ctrl_consts.vh ====
// Offsets, field positions, reset values, keys and timing counts for the converter control block.
// Assumes inclusion by the design file and the bench; definitions only.
`ifndef DAC_CTRL_CONSTS_VH
`define DAC_CTRL_CONSTS_VH

// ----------------------------------------
// Register byte offsets (APB; single registers one word, channel banks one word per channel)
// ----------------------------------------
`define OFS_CMD_KEY        12'h000
`define OFS_ALERT_STATUS   12'h004
`define OFS_LIVE_STATUS    12'h008
`define OFS_ALERT_MASK     12'h00C
`define OFS_THERM_CTRL     12'h010
`define OFS_SETUP_BASE     12'h020
`define OFS_TARGET_BASE    12'h030
`define OFS_CLEAR_BASE     12'h040
`define OFS_ACTIVE_BASE    12'h050
`define OFS_SELECT_MASK    12'hFF0

// ----------------------------------------
// Command keys
// ----------------------------------------
`define KEY_CLEAR          16'h73D1
`define KEY_LOAD           16'h953A
`define KEY_SWRST1         16'h15FA
`define KEY_SWRST2         16'hAF51

// ----------------------------------------
// Channel setup fields
// ----------------------------------------
`define SETUP_CLEAR_ENABLE       0
`define SETUP_SLEW_EN      1
`define SETUP_STEP_LSB     2
`define SETUP_RATE_LSB     4
`define SETUP_WIDTH        6

// ----------------------------------------
// Slew step sizes (codes)
// ----------------------------------------
`define STEP_0             13'd64
`define STEP_1             13'd120
`define STEP_2             13'd500
`define STEP_3             13'd1820

// ----------------------------------------
// Update rates in kHz and clock rate in kHz
// ----------------------------------------
`define CLK_KHZ            100000
`define RATE0_KHZ          4
`define RATE1_KHZ          64
`define RATE2_KHZ          150
`define RATE3_KHZ          240

// ----------------------------------------
// Alert status bit positions
// ----------------------------------------
`define AL_RESET_SEEN      0
`define AL_CAL_MEM_ERR     1
`define AL_OVER_TEMP       2
`define AL_CH_FAULT_LSB    3
`define AL_WIDTH           15

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define RESET_TIME_US      1000
`define ALERT_MASK_RST     15'h0000

`endif

// ==== hw/dac_clear_slew_reset_alert.v ====
// Converter control: clear key, load strobe, linear slew, resets, alert status and mask.
// Assumes a 100 MHz pclk, an APB master, synchronous inputs and external comparator indications.
//
// The APB register port and the placing of the registers were left to the implementer.
`include "dac_ctrl_consts.vh"

// How it works
// - Clear key loads the stored 13-bit clear value on clear-enabled channels.
// - Channels without clear enable keep their code on the clear key, dropping a load in that cycle.
// - Active code register updates in the cycle the converter code changes.
// - Clear beats a simultaneous load strobe or load key.
// - Slew disabled: target passes to converter in one step.
// - Slew enabled: each update moves by up to 64, 120, 500 or 1820 codes.
// - Slew updates occur at 4, 64, 150 or 240 kHz.
// - Active code register always returns the applied converter code.
// - With slew on, a clear steps toward the clear value.
// - Any reset restores defaults, refreshes calibration, sets outputs high-impedance.
// - Low pulse on reset pin starts a full hardware reset.
// - Software reset only after key 0x15FA then key 0xAF51.
// - Held in reset while power-good reports low supplies.
// - Completed reset cycle sets the reset-seen flag.
// - Register access during reset cycle sets calibration-memory error flag.
// - Over-temperature indication at 110 C sets the over-temp flag.
// - With thermal reset enabled, 140 C indication causes full reset.
// - Alert status bits are sticky, cleared by writing one.
// - Live status reflects conditions directly without latching.
// - Alert output follows latched alerts not masked.
// - Key 0x73D1 is the clear request.
// - Load strobe low or load key moves target codes to converters.
// - Alert output is active low.
module dac_clear_slew_reset_alert #(
  parameter CHANNELS      = 4,
  parameter CODE_W        = 13,
  parameter RESET_CYCLES  = (`RESET_TIME_US * (`CLK_KHZ / 1000))
) (
  input  wire                         pclk,
  input  wire                         presetn,
  input  wire                         psel,
  input  wire                         penable,
  input  wire                         pwrite,
  input  wire [11:0]                  paddr,
  input  wire [31:0]                  pwdata,
  output reg  [31:0]                  prdata,
  output wire                         pready,
  output wire                         pslverr,
  input  wire                         reset_pin_n,
  input  wire                         power_good,
  input  wire                         temp_110,
  input  wire                         temp_140,
  input  wire                         load_strobe_n,
  input  wire [CHANNELS*3-1:0]        channel_fault,
  output reg  [CHANNELS*CODE_W-1:0]   dac_code,
  output reg  [CHANNELS-1:0]          output_hiz,
  output wire                         alert_n,
  output wire                         cal_refresh
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function [12:0] step_of;
    input [1:0] sel;
    begin
      case (sel)
        2'd0:    step_of = `STEP_0;
        2'd1:    step_of = `STEP_1;
        2'd2:    step_of = `STEP_2;
        default: step_of = `STEP_3;
      endcase
    end
  endfunction

  // Divisors truncate, so a rate may run up to 0.2 percent fast
  localparam integer DIV0 = `CLK_KHZ / `RATE0_KHZ;
  localparam integer DIV1 = `CLK_KHZ / `RATE1_KHZ;
  localparam integer DIV2 = `CLK_KHZ / `RATE2_KHZ;
  localparam integer DIV3 = `CLK_KHZ / `RATE3_KHZ;

  function [15:0] div_of;
    input [1:0] sel;
    begin
      case (sel)
        2'd0:    div_of = DIV0[15:0];
        2'd1:    div_of = DIV1[15:0];
        2'd2:    div_of = DIV2[15:0];
        default: div_of = DIV3[15:0];
      endcase
    end
  endfunction

  // Equal codes leave the output still, so an idle engine only runs its divider
  function [12:0] slew_next;
    input [12:0] cur;
    input [12:0] goal;
    input [12:0] step;
    begin
      if (goal > cur) begin
        if (goal - cur <= step)
          slew_next = goal;
        else
          slew_next = cur + step;
      end else if (goal < cur) begin
        if (cur - goal <= step)
          slew_next = goal;
        else
          slew_next = cur - step;
      end else begin
        slew_next = cur;
      end
    end
  endfunction

  // ----------------------------------------
  // Reset sequencer
  // ----------------------------------------
  localparam [2:0] ST_RESET = 3'b001;
  localparam [2:0] ST_CAL   = 3'b010;
  localparam [2:0] ST_RUN   = 3'b100;

  reg  [2:0]  state_reg;
  reg  [31:0] rst_cnt_reg;
  reg         swrst_armed_reg;
  reg         soft_reset_reg;
  reg         therm_en_reg;
  reg         cal_access_reg;
  reg         reset_done_reg;
  wire        therm_reset;
  wire        pin_reset;
  wire        supply_reset;
  wire        int_reset;
  wire        running;
  wire        wr_en;
  wire        rd_en;

  assign therm_reset  = therm_en_reg & temp_140;
  assign pin_reset    = ~reset_pin_n;
  assign supply_reset = ~power_good;
  // Internal resets act through the synchronous path so no flop is reset from logic asynchronously
  assign int_reset    = pin_reset | supply_reset | soft_reset_reg | therm_reset;
  assign running      = state_reg == ST_RUN;
  assign cal_refresh  = state_reg == ST_CAL;
  assign wr_en        = psel & penable & pwrite;
  // Read data is fetched in the setup cycle so it already stands in the access phase
  assign rd_en        = psel & ~penable & ~pwrite;
  assign pready       = 1'b1;
  assign pslverr      = 1'b0;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg      <= ST_RESET;
      rst_cnt_reg    <= 32'd0;
      reset_done_reg <= 1'b0;
    end else if (int_reset) begin
      state_reg      <= ST_RESET;
      rst_cnt_reg    <= 32'd0;
      reset_done_reg <= 1'b0;
    end else begin
      reset_done_reg <= 1'b0;
      case (state_reg)
        ST_RESET: state_reg <= ST_CAL;
        // The refresh window spans exactly RESET_CYCLES edges in this state
        ST_CAL: begin
          if (rst_cnt_reg >= RESET_CYCLES - 1) begin
            state_reg      <= ST_RUN;
            reset_done_reg <= 1'b1;
          end else begin
            rst_cnt_reg <= rst_cnt_reg + 32'd1;
          end
        end
        ST_RUN:   state_reg <= ST_RUN;
        default:  state_reg <= ST_RESET;
      endcase
    end
  end

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  wire        reg_wr;
  wire [11:0] page;
  wire        hit_key;
  wire        hit_alert;
  wire        hit_mask;
  wire        hit_therm;
  wire        hit_setup;
  wire        hit_target;
  wire        hit_clear;

  // Writes are dropped until the reset cycle ends, so a refresh cannot be disturbed
  assign reg_wr     = wr_en & running;
  assign page       = paddr & `OFS_SELECT_MASK;
  assign hit_key    = reg_wr & (paddr == `OFS_CMD_KEY);
  assign hit_alert  = reg_wr & (paddr == `OFS_ALERT_STATUS);
  assign hit_mask   = reg_wr & (paddr == `OFS_ALERT_MASK);
  assign hit_therm  = reg_wr & (paddr == `OFS_THERM_CTRL);
  assign hit_setup  = reg_wr & (page == `OFS_SETUP_BASE);
  assign hit_target = reg_wr & (page == `OFS_TARGET_BASE);
  assign hit_clear  = reg_wr & (page == `OFS_CLEAR_BASE);

  // ----------------------------------------
  // Command keys
  // ----------------------------------------
  wire        key_wr;
  wire        clear_cmd;
  wire        load_key;

  assign key_wr    = hit_key;
  assign clear_cmd = key_wr & (pwdata[15:0] == `KEY_CLEAR);
  assign load_key  = key_wr & (pwdata[15:0] == `KEY_LOAD);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swrst_armed_reg <= 1'b0;
      soft_reset_reg  <= 1'b0;
    end else begin
      soft_reset_reg <= 1'b0;
      if (int_reset) begin
        swrst_armed_reg <= 1'b0;
      end else if (key_wr) begin
        // Any other key breaks the pair, so a stray second key cannot reset the part
        swrst_armed_reg <= (pwdata[15:0] == `KEY_SWRST1);
        soft_reset_reg  <= swrst_armed_reg & (pwdata[15:0] == `KEY_SWRST2);
      end
    end
  end

  // ----------------------------------------
  // Channel registers and slew engines
  // ----------------------------------------
  reg  [`SETUP_WIDTH-1:0] setup_reg  [0:CHANNELS-1];
  reg  [CODE_W-1:0]       target_reg [0:CHANNELS-1];
  reg  [CODE_W-1:0]       clear_reg  [0:CHANNELS-1];
  reg  [CODE_W-1:0]       goal_reg   [0:CHANNELS-1];
  // One divider per channel, so channels on different rates never share a tick
  reg  [15:0]             div_reg    [0:CHANNELS-1];
  wire                    load_now;
  wire [3:0]              ch_sel;
  integer                 i;

  assign load_now = ~load_strobe_n | load_key;
  assign ch_sel   = {2'b00, paddr[3:2]};

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < CHANNELS; i = i + 1) begin
        setup_reg[i]  <= {`SETUP_WIDTH{1'b0}};
        target_reg[i] <= {CODE_W{1'b0}};
        clear_reg[i]  <= {CODE_W{1'b0}};
        goal_reg[i]   <= {CODE_W{1'b0}};
        div_reg[i]    <= 16'h0000;
        dac_code[i*CODE_W +: CODE_W] <= {CODE_W{1'b0}};
      end
      output_hiz <= {CHANNELS{1'b1}};
    end else if (int_reset) begin
      for (i = 0; i < CHANNELS; i = i + 1) begin
        setup_reg[i]  <= {`SETUP_WIDTH{1'b0}};
        target_reg[i] <= {CODE_W{1'b0}};
        clear_reg[i]  <= {CODE_W{1'b0}};
        goal_reg[i]   <= {CODE_W{1'b0}};
        div_reg[i]    <= 16'h0000;
        dac_code[i*CODE_W +: CODE_W] <= {CODE_W{1'b0}};
      end
      output_hiz <= {CHANNELS{1'b1}};
    end else if (running) begin
      for (i = 0; i < CHANNELS; i = i + 1) begin
        if (ch_sel == i[3:0]) begin
          if (hit_setup) begin
            setup_reg[i]  <= pwdata[`SETUP_WIDTH-1:0];
            output_hiz[i] <= 1'b0;
          end
          if (hit_target)
            target_reg[i] <= pwdata[CODE_W-1:0];
          if (hit_clear)
            clear_reg[i]  <= pwdata[CODE_W-1:0];
        end
        // Clear checked first so it wins over a strobe in the same cycle
        if (clear_cmd) begin
          if (setup_reg[i][`SETUP_CLEAR_ENABLE])
            goal_reg[i] <= clear_reg[i];
        end else if (load_now) begin
          goal_reg[i] <= target_reg[i];
        end
        if (!setup_reg[i][`SETUP_SLEW_EN]) begin
          // One-step path: converter and readback share one register
          if (clear_cmd) begin
            if (setup_reg[i][`SETUP_CLEAR_ENABLE])
              dac_code[i*CODE_W +: CODE_W] <= clear_reg[i];
          end else if (load_now) begin
            dac_code[i*CODE_W +: CODE_W] <= target_reg[i];
          end
          div_reg[i] <= 16'h0000;
        end else if (div_reg[i] >= div_of(setup_reg[i][`SETUP_RATE_LSB +: 2]) - 16'd1) begin
          div_reg[i] <= 16'h0000;
          dac_code[i*CODE_W +: CODE_W] <= slew_next(dac_code[i*CODE_W +: CODE_W], goal_reg[i],
            step_of(setup_reg[i][`SETUP_STEP_LSB +: 2]));
        end else begin
          div_reg[i] <= div_reg[i] + 16'd1;
        end
      end
    end
  end

  // ----------------------------------------
  // Alert status, mask and thermal control
  // ----------------------------------------
  reg  [`AL_WIDTH-1:0] alert_reg;
  reg  [`AL_WIDTH-1:0] mask_reg;
  wire [`AL_WIDTH-1:0] live;
  wire [`AL_WIDTH-1:0] clr_bits;

  assign live     = {channel_fault, temp_110, 1'b0, 1'b0};
  assign clr_bits = hit_alert ? pwdata[`AL_WIDTH-1:0]
                              : {`AL_WIDTH{1'b0}};
  assign alert_n  = ~|(alert_reg & ~mask_reg);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_access_reg <= 1'b0;
    end else if (running) begin
      cal_access_reg <= 1'b0;
    end else if (psel & penable) begin
      cal_access_reg <= 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alert_reg    <= {`AL_WIDTH{1'b0}};
      mask_reg     <= `ALERT_MASK_RST;
      therm_en_reg <= 1'b0;
    end else if (int_reset) begin
      alert_reg    <= {`AL_WIDTH{1'b0}};
      mask_reg     <= `ALERT_MASK_RST;
      therm_en_reg <= 1'b0;
    end else begin
      // Set wins over a write-one clear in the same cycle
      alert_reg <= (alert_reg & ~clr_bits) | live;
      if (reset_done_reg) begin
        alert_reg[`AL_RESET_SEEN]  <= 1'b1;
        alert_reg[`AL_CAL_MEM_ERR] <= cal_access_reg | (alert_reg[`AL_CAL_MEM_ERR] & ~clr_bits[`AL_CAL_MEM_ERR]);
      end
      if (hit_mask)
        mask_reg <= pwdata[`AL_WIDTH-1:0];
      if (hit_therm)
        therm_en_reg <= pwdata[0];
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      prdata <= 32'h00000000;
      case (page)
        `OFS_SETUP_BASE:  prdata <= {{(32-`SETUP_WIDTH){1'b0}}, setup_reg[ch_sel[1:0]]};
        `OFS_TARGET_BASE: prdata <= {{(32-CODE_W){1'b0}}, target_reg[ch_sel[1:0]]};
        `OFS_CLEAR_BASE:  prdata <= {{(32-CODE_W){1'b0}}, clear_reg[ch_sel[1:0]]};
        `OFS_ACTIVE_BASE: prdata <= {{(32-CODE_W){1'b0}}, dac_code[ch_sel[1:0]*CODE_W +: CODE_W]};
        default: begin
          if (paddr == `OFS_ALERT_STATUS) prdata <= {{(32-`AL_WIDTH){1'b0}}, alert_reg};
          if (paddr == `OFS_LIVE_STATUS)  prdata <= {{(32-`AL_WIDTH){1'b0}}, live};
          if (paddr == `OFS_ALERT_MASK)   prdata <= {{(32-`AL_WIDTH){1'b0}}, mask_reg};
          if (paddr == `OFS_THERM_CTRL)   prdata <= {31'h00000000, therm_en_reg};
        end
      endcase
    end
  end

endmodule

// ==== test/dac_ctrl_checker_asserts.sv ====
// Checker for the converter control block, bound to its top module.
// Assumes only top-level ports; reset windows are seen on cal_refresh.
module dac_ctrl_checker #(
  parameter CHANNELS     = 4,
  parameter CODE_W       = 13,
  parameter RESET_CYCLES = 20
) (
  input wire logic                         pclk,
  input wire logic                         presetn,
  input wire logic                         reset_pin_n,
  input wire logic                         power_good,
  input wire logic                         temp_110,
  input wire logic [CHANNELS*3-1:0]        channel_fault,
  input wire logic [CHANNELS*CODE_W-1:0]   dac_code,
  input wire logic [CHANNELS-1:0]          output_hiz,
  input wire logic                         alert_n,
  input wire logic                         cal_refresh
);
  timeunit 1ns;
  timeprecision 100ps;
  int cal_cnt;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Window too long for a repetition, so it is counted
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) cal_cnt <= 0;
    else cal_cnt <= cal_refresh ? cal_cnt + 1 : 0;
  end
  a_cal_hiz: assert property (cal_refresh |-> &output_hiz)
    else $error("outputs driven in reset");
  a_cal_code: assert property (cal_refresh |-> dac_code == '0)
    else $error("code not cleared in reset");
  a_cal_len: assert property ($fell(cal_refresh) |-> cal_cnt >= RESET_CYCLES && cal_cnt <= RESET_CYCLES + 2)
    else $error("refresh length wrong");
  a_pin_reset: assert property ($rose(reset_pin_n) |-> ##[0:4] cal_refresh)
    else $error("pin reset missing");
  a_pgood_reset: assert property ($rose(power_good) |-> ##[0:4] cal_refresh)
    else $error("supply reset missing");
  a_seen_alert: assert property ($fell(cal_refresh) |-> ##[0:2] !alert_n)
    else $error("no alert after reset");
  a_temp_alert: assert property ($rose(temp_110) |-> ##[1:3] !alert_n)
    else $error("no alert on heat");
  a_fault_alert: assert property ($rose(|channel_fault) |-> ##[1:3] !alert_n)
    else $error("no alert on fault");
endmodule
bind dac_clear_slew_reset_alert dac_ctrl_checker #(.CHANNELS(CHANNELS), .CODE_W(CODE_W), .RESET_CYCLES(RESET_CYCLES))
  dac_ctrl_checker_inst (.pclk(pclk), .presetn(presetn), .reset_pin_n(reset_pin_n), .power_good(power_good),
  .temp_110(temp_110), .channel_fault(channel_fault), .dac_code(dac_code), .output_hiz(output_hiz),
  .alert_n(alert_n), .cal_refresh(cal_refresh));

// ==== test/apb_host_model.sv ====
// Host model: one APB transfer at a time, request held until pready.
// Assumes calls from the bench's main process only.
module apb_host_model (
  input  wire logic        pclk,
  input  wire logic        pready,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'hFFF;
    pwdata = 32'h0;
  end
  // An edge passes first, so back-to-back calls never drive twice in one step
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule

// ==== test/dac_clear_slew_reset_alert_bench.sv ====
// Bench for the converter control block: host model, queue of expected reads.
// Assumes the constants header on the include path; reset window set to 20.
`include "dac_ctrl_consts.vh"
module dac_clear_slew_reset_alert_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, alert_n, cal_refresh;
  logic        reset_pin_n, power_good, temp_110, temp_140, load_strobe_n;
  logic [11:0] paddr, channel_fault;
  logic [31:0] pwdata, prdata, expq[$];
  logic [51:0] dac_code;
  logic [3:0]  output_hiz;
  logic [12:0] tgt[4], clr[4], expc[4], cur, goal;
  logic [15:0] seed;
  int          n_errors = 0, checks = 0, cyc = 0, t0, p;
  int          step[4] = '{`STEP_0, `STEP_1, `STEP_2, `STEP_3};
  int          rate[4] = '{`RATE0_KHZ, `RATE1_KHZ, `RATE2_KHZ, `RATE3_KHZ};

  dac_clear_slew_reset_alert #(.RESET_CYCLES(20)) dac_clear_slew_reset_alert_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reset_pin_n(reset_pin_n), .power_good(power_good), .temp_110(temp_110), .temp_140(temp_140),
    .load_strobe_n(load_strobe_n), .channel_fault(channel_fault), .dac_code(dac_code),
    .output_hiz(output_hiz), .alert_n(alert_n), .cal_refresh(cal_refresh));
  apb_host_model apb_host_model_inst (.pclk(pclk), .pready(pready), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb_host_model_inst.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    expq.push_back(e);
    apb_host_model_inst.xfer(1'b0, a, 32'h0);
  endtask
  task automatic rd_all;
    for (int c = 0; c < 4; c++) rd(`OFS_ACTIVE_BASE + 12'(4 * c), {19'h0, expc[c]});
  endtask
  task automatic wait_step;
    logic [12:0] was;
    int n;
    was = dac_code[25:13];
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (dac_code[25:13] === was && n < 30000);
  endtask
  // Window length is fixed by the reset parameter, so a fixed wait is safe
  task automatic rst_check;
    repeat (25) @(posedge pclk);
    cmp({pslverr, output_hiz}, 5'h0F);
    rd(`OFS_ALERT_STATUS, 32'h1);
    rd(`OFS_THERM_CTRL, 32'h0);
    wr(`OFS_ALERT_STATUS, 32'h1);
    $display("reset test done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) cyc <= cyc + 1;
  always @(posedge pclk)
    if (psel && penable && pready === 1'b1 && !pwrite && expq.size() > 0) cmp(prdata, expq.pop_front());
  initial begin
    repeat (100000) @(posedge pclk);
    n_errors++;
    close_out;
  end

  initial begin
    presetn = 1'b0;
    reset_pin_n = 1'b1;
    power_good = 1'b1;
    temp_110 = 1'b0;
    temp_140 = 1'b0;
    load_strobe_n = 1'b1;
    channel_fault = 12'h000;
    seed = 16'hF0EE;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    wr(`OFS_CMD_KEY, 32'h0);
    repeat (25) @(posedge pclk);
    rd(`OFS_ALERT_STATUS, 32'h3);
    wr(`OFS_ALERT_STATUS, 32'h0);
    rd(`OFS_ALERT_STATUS, 32'h3);
    wr(`OFS_ALERT_STATUS, 32'h3);
    rd(12'h100, 32'h0);
    $display("flags test done");
    for (int c = 0; c < 4; c++) begin
      seed = lfsr(seed);
      tgt[c] = seed[12:0];
      clr[c] = ~seed[12:0];
      expc[c] = tgt[c];
      wr(`OFS_SETUP_BASE + 12'(4 * c), {31'h0, ~c[0]});
      wr(`OFS_TARGET_BASE + 12'(4 * c), {19'h0, tgt[c]});
      wr(`OFS_CLEAR_BASE + 12'(4 * c), {19'h0, clr[c]});
    end
    wr(`OFS_CMD_KEY, {16'h0, `KEY_LOAD});
    rd_all;
    for (int c = 0; c < 4; c++) begin
      seed = lfsr(seed);
      tgt[c] = seed[12:0];
      wr(`OFS_TARGET_BASE + 12'(4 * c), {19'h0, tgt[c]});
    end
    rd_all;
    wr(`OFS_CMD_KEY, {16'h0, `KEY_CLEAR});
    expc[0] = clr[0];
    expc[2] = clr[2];
    rd_all;
    load_strobe_n <= 1'b0;
    @(posedge pclk);
    load_strobe_n <= 1'b1;
    expc = tgt;
    rd_all;
    load_strobe_n <= 1'b0;
    wr(`OFS_CMD_KEY, {16'h0, `KEY_CLEAR});
    load_strobe_n <= 1'b1;
    expc[0] = clr[0];
    expc[2] = clr[2];
    rd_all;
    $display("clear test done");
    wr(`OFS_SETUP_BASE + 12'h4, 32'h0);
    wr(`OFS_TARGET_BASE + 12'h4, 32'h0);
    wr(`OFS_CMD_KEY, {16'h0, `KEY_LOAD});
    cur = 13'h0000;
    for (int i = 0; i < 4; i++) begin
      goal = cur + 13'(step[i] + 37);
      p = `CLK_KHZ / rate[3 - i];
      wr(`OFS_SETUP_BASE + 12'h4, 32'(2 + 4 * i + 16 * (3 - i)));
      wr(`OFS_TARGET_BASE + 12'h4, {19'h0, goal});
      wr(`OFS_CMD_KEY, {16'h0, `KEY_LOAD});
      cur = cur + 13'(step[i]);
      wait_step;
      t0 = cyc;
      cmp(dac_code[25:13], cur);
      rd(`OFS_ACTIVE_BASE + 12'h4, {19'h0, cur});
      wait_step;
      cmp(dac_code[25:13], goal);
      cmp(32'(cyc - t0 >= p - 1 && cyc - t0 <= p + 1), 32'h1);
      cur = goal;
    end
    wr(`OFS_CLEAR_BASE + 12'h4, 32'h0);
    wr(`OFS_SETUP_BASE + 12'h4, 32'h3F);
    wr(`OFS_CMD_KEY, {16'h0, `KEY_CLEAR});
    wait_step;
    cmp(dac_code[25:13], cur - `STEP_3);
    $display("slew test done");
    temp_110 <= 1'b1;
    repeat (3) @(posedge pclk);
    rd(`OFS_LIVE_STATUS, 32'h4);
    temp_110 <= 1'b0;
    repeat (3) @(posedge pclk);
    rd(`OFS_LIVE_STATUS, 32'h0);
    for (int j = 0; j < 12; j++) begin
      channel_fault <= 12'h001 << j;
      repeat (3) @(posedge pclk);
      rd(`OFS_LIVE_STATUS, 32'h8 << j);
      channel_fault <= 12'h000;
      @(posedge pclk);
    end
    rd(`OFS_ALERT_STATUS, 32'h7FFC);
    wr(`OFS_ALERT_MASK, 32'h7FFC);
    @(posedge pclk);
    cmp(alert_n, 1'b1);
    wr(`OFS_ALERT_MASK, 32'h0);
    @(posedge pclk);
    cmp(alert_n, 1'b0);
    wr(`OFS_ALERT_STATUS, 32'h7FFC);
    @(posedge pclk);
    cmp(alert_n, 1'b1);
    $display("alert test done");
    wr(`OFS_CMD_KEY, {16'h0, `KEY_SWRST2});
    repeat (3) @(posedge pclk);
    cmp(cal_refresh, 1'b0);
    wr(`OFS_CMD_KEY, {16'h0, `KEY_SWRST1});
    wr(`OFS_CMD_KEY, {16'h0, `KEY_SWRST2});
    rst_check;
    wr(`OFS_THERM_CTRL, 32'h1);
    temp_140 <= 1'b1;
    repeat (3) @(posedge pclk);
    temp_140 <= 1'b0;
    rst_check;
    reset_pin_n <= 1'b0;
    repeat (3) @(posedge pclk);
    reset_pin_n <= 1'b1;
    rst_check;
    power_good <= 1'b0;
    repeat (3) @(posedge pclk);
    power_good <= 1'b1;
    rst_check;
    close_out;
  end
endmodule
